// *** pkg/irtr_regs.svh ***
// Register indices, field positions, reset values and sizes of the remap table
`ifndef IRTR_REGS_SVH
`define IRTR_REGS_SVH

// Register indices; byte address on the bus is four times the index
`define IRTR_IDX_TARGET_BASE 8'h70
`define IRTR_IDX_TARGET1     8'h70
`define IRTR_IDX_TARGET2     8'h71
`define IRTR_IDX_TARGET3     8'h72
`define IRTR_IDX_TARGET4     8'h73
`define IRTR_IDX_ALIAS_BASE  8'h77
`define IRTR_IDX_ALIAS1      8'h77
`define IRTR_IDX_ALIAS2      8'h78
`define IRTR_IDX_ALIAS3      8'h79
`define IRTR_IDX_ALIAS4      8'h7A
`define IRTR_IDX_STATUS      8'h7B

// Field positions
`define IRTR_ADDR_MSB        7
`define IRTR_ADDR_LSB        1
`define IRTR_STAT_SLOT_LSB   0
`define IRTR_STAT_SLOT_MSB   1
`define IRTR_STAT_HIT        2
`define IRTR_STAT_MISS_LSB   8
`define IRTR_STAT_MISS_MSB   15

// Reset values and sizes
`define IRTR_ADDR_RESET      7'h00
`define IRTR_SLOTS           4
`define IRTR_WB_IDX_MSB      9
`define IRTR_WB_IDX_LSB      2

`endif

// *** pkg/irtr_pkg.sv ***
// Types shared by the remote target remap block
`default_nettype none
package irtr_pkg;

    typedef enum logic [1:0]
    {
        IRTR_IDLE = 2'b00,
        IRTR_HOLD = 2'b01
    } irtr_phase_type;

    // Address phase from the local controller front end
    typedef struct packed
    {
        logic       valid;
        logic [6:0] addr;
        logic       rw;
    } irtr_req_type;

    // Remapped address phase toward the control channel
    typedef struct packed
    {
        logic       valid;
        logic [6:0] addr;
        logic       rw;
        logic [1:0] slot;
    } irtr_fwd_type;

    typedef struct packed
    {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [9:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } irtr_wb_req_type;

    typedef struct packed
    {
        logic        ack;
        logic [31:0] dat;
    } irtr_wb_rsp_type;

    typedef struct packed
    {
        irtr_phase_type  phase;
        logic [3:0][6:0] target;
        logic [3:0][6:0] alias_addr;
        logic            ack;
        logic [7:0]      rdata;
        irtr_fwd_type    fwd;
        logic            reject;
        logic            last_hit;
        logic [1:0]      last_slot;
        logic [7:0]      miss_count;
    } irtr_state_type;

endpackage
`default_nettype wire

// *** hw/irtr_slot.sv ***
// One remap slot: enable check and full alias compare
`timescale 1ns/10ps
`default_nettype none
module irtr_slot
(
    // Slot contents
    input  wire logic [6:0] alias_addr,
    input  wire logic [6:0] target,
    // Incoming address
    input  wire logic [6:0] in_addr,
    // Result
    output logic            hit
);

    logic enabled;

    assign enabled = (alias_addr != 7'h00) && (target != 7'h00);
    assign hit     = enabled && (in_addr == alias_addr);

endmodule
`default_nettype wire

// *** hw/irtr_select.sv ***
// Lowest-numbered pick among slot hits
`timescale 1ns/10ps
`default_nettype none
module irtr_select
#(
    parameter int N = 4
)
(
    // Slot hits
    input  wire logic [N-1:0]         hits,
    // Pick
    output logic                      any,
    output logic [$clog2(N)-1:0]      index
);

    always_comb
    begin
        any   = 1'b0;
        index = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (hits[i])
            begin
                any   = 1'b1;
                index = ($clog2(N))'(i);
            end
        end
    end

endmodule
`default_nettype wire

// *** hw/irtr_remap.sv ***
// Remote target address remap table with its Wishbone register slave
//
// What this block does
// - Each target slot register keeps a 7-bit remote peripheral address in bits 7:1.
// - An address phase that equals a slot's alias is forwarded carrying that slot's target address.
// - Only the already substituted address is ever presented on the forward port.
// - A target of zero disables its slot so nothing is forwarded for it, and targets reset to zero.
// - Four independent slots exist, each with its own target, and bit 0 of each slot register is reserved.
// - Each slot has a 7-bit alias in bits 7:1, and an alias of zero also disables the slot.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "irtr_regs.svh"
module irtr_remap
(
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    // Register bus
    input  wire irtr_pkg::irtr_wb_req_type wb_req,
    output irtr_pkg::irtr_wb_rsp_type      wb_rsp,
    // Address phase from the local controller
    input  wire irtr_pkg::irtr_req_type    req,
    output logic                           req_ready,
    output logic                           reject,
    // Remapped address phase to the control channel
    output irtr_pkg::irtr_fwd_type         fwd,
    input  wire logic                      fwd_ready
);
    import irtr_pkg::*;

    // Table state and slot match
    irtr_state_type        state;
    irtr_state_type        next_state;
    logic [`IRTR_SLOTS-1:0] hits;
    logic                  any_hit;
    logic [1:0]            hit_index;
    logic [6:0]            sel_target;
    // Register bus decode
    logic [7:0]            wb_idx;
    logic                  wb_take;
    logic                  wb_write;
    logic [3:0]            target_wr;
    logic [3:0]            alias_wr;
    logic [7:0]            read_mux;

    // One compare per slot; lowest slot wins in the selector
    irtr_slot u_slot1
    (
        .alias_addr (state.alias_addr[0]),
        .target     (state.target[0]),
        .in_addr    (req.addr),
        .hit        (hits[0])
    );

    irtr_slot u_slot2
    (
        .alias_addr (state.alias_addr[1]),
        .target     (state.target[1]),
        .in_addr    (req.addr),
        .hit        (hits[1])
    );

    irtr_slot u_slot3
    (
        .alias_addr (state.alias_addr[2]),
        .target     (state.target[2]),
        .in_addr    (req.addr),
        .hit        (hits[2])
    );

    irtr_slot u_slot4
    (
        .alias_addr (state.alias_addr[3]),
        .target     (state.target[3]),
        .in_addr    (req.addr),
        .hit        (hits[3])
    );

    irtr_select #(.N(`IRTR_SLOTS)) u_select
    (
        .hits  (hits),
        .any   (any_hit),
        .index (hit_index)
    );

    // Stored target of the winning slot
    always_comb
    begin
        case (hit_index)
            2'h0:
            begin
                sel_target = state.target[0];
            end
            2'h1:
            begin
                sel_target = state.target[1];
            end
            2'h2:
            begin
                sel_target = state.target[2];
            end
            2'h3:
            begin
                sel_target = state.target[3];
            end
            default:
            begin
                sel_target = 7'h00;
            end
        endcase
    end

    assign wb_idx   = wb_req.adr[`IRTR_WB_IDX_MSB:`IRTR_WB_IDX_LSB];
    assign wb_take  = wb_req.cyc && wb_req.stb && !state.ack;
    assign wb_write = wb_take && wb_req.we && wb_req.sel[0];

    // Read data; reserved bit 0 and unmapped indices read zero
    always_comb
    begin
        case (wb_idx)
            `IRTR_IDX_TARGET1:
            begin
                read_mux = {state.target[0], 1'b0};
            end
            `IRTR_IDX_TARGET2:
            begin
                read_mux = {state.target[1], 1'b0};
            end
            `IRTR_IDX_TARGET3:
            begin
                read_mux = {state.target[2], 1'b0};
            end
            `IRTR_IDX_TARGET4:
            begin
                read_mux = {state.target[3], 1'b0};
            end
            `IRTR_IDX_ALIAS1:
            begin
                read_mux = {state.alias_addr[0], 1'b0};
            end
            `IRTR_IDX_ALIAS2:
            begin
                read_mux = {state.alias_addr[1], 1'b0};
            end
            `IRTR_IDX_ALIAS3:
            begin
                read_mux = {state.alias_addr[2], 1'b0};
            end
            `IRTR_IDX_ALIAS4:
            begin
                read_mux = {state.alias_addr[3], 1'b0};
            end
            `IRTR_IDX_STATUS:
            begin
                read_mux = {5'h00, state.last_hit, state.last_slot};
            end
            default:
            begin
                read_mux = 8'h00;
            end
        endcase
    end

    // One write strobe per table register; status is read only
    always_comb
    begin
        target_wr = 4'h0;
        alias_wr  = 4'h0;
        if (wb_write)
        begin
            case (wb_idx)
                `IRTR_IDX_TARGET1:
                begin
                    target_wr[0] = 1'b1;
                end
                `IRTR_IDX_TARGET2:
                begin
                    target_wr[1] = 1'b1;
                end
                `IRTR_IDX_TARGET3:
                begin
                    target_wr[2] = 1'b1;
                end
                `IRTR_IDX_TARGET4:
                begin
                    target_wr[3] = 1'b1;
                end
                `IRTR_IDX_ALIAS1:
                begin
                    alias_wr[0] = 1'b1;
                end
                `IRTR_IDX_ALIAS2:
                begin
                    alias_wr[1] = 1'b1;
                end
                `IRTR_IDX_ALIAS3:
                begin
                    alias_wr[2] = 1'b1;
                end
                `IRTR_IDX_ALIAS4:
                begin
                    alias_wr[3] = 1'b1;
                end
                default:
                begin
                    target_wr = 4'h0;
                    alias_wr  = 4'h0;
                end
            endcase
        end
    end

    // Next state: register access and address phase
    always_comb
    begin
        next_state        = state;
        next_state.ack    = 1'b0;
        next_state.reject = 1'b0;

        // Register access, answered one cycle after the request edge
        if (wb_take)
        begin
            next_state.ack   = 1'b1;
            next_state.rdata = read_mux;
            for (int i = 0; i < `IRTR_SLOTS; i++)
            begin
                if (target_wr[i])
                begin
                    next_state.target[i] = wb_req.dat[`IRTR_ADDR_MSB:`IRTR_ADDR_LSB];
                end
                if (alias_wr[i])
                begin
                    next_state.alias_addr[i] = wb_req.dat[`IRTR_ADDR_MSB:`IRTR_ADDR_LSB];
                end
            end
        end

        // Address phase handling
        case (state.phase)
            IRTR_IDLE:
            begin
                if (req.valid)
                begin
                    if (any_hit)
                    begin
                        next_state.fwd.valid  = 1'b1;
                        next_state.fwd.addr   = sel_target;
                        next_state.fwd.rw     = req.rw;
                        next_state.fwd.slot   = hit_index;
                        next_state.last_hit   = 1'b1;
                        next_state.last_slot  = hit_index;
                        next_state.phase      = IRTR_HOLD;
                    end
                    else
                    begin
                        // No enabled slot matches: dropped
                        next_state.reject     = 1'b1;
                        next_state.last_hit   = 1'b0;
                        next_state.miss_count = state.miss_count + 8'h01;
                    end
                end
            end
            IRTR_HOLD:
            begin
                // Latched phase stays fixed even if the table is rewritten
                if (fwd_ready)
                begin
                    next_state.fwd.valid = 1'b0;
                    next_state.phase     = IRTR_IDLE;
                end
            end
            default:
            begin
                next_state.phase     = IRTR_IDLE;
                next_state.fwd.valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Register bus answer; bits 31:8 always read zero
    assign wb_rsp.ack = state.ack;
    assign wb_rsp.dat = {24'h00_0000, state.rdata};

    // Address phase outputs
    assign req_ready  = (state.phase == IRTR_IDLE);
    assign reject     = state.reject;
    assign fwd        = state.fwd;

endmodule
`default_nettype wire

// *** tb/irtr_remap_properties.sv ***
// Port assertions for the remap block
`timescale 1ns/10ps
`default_nettype none
module irtr_remap_props
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register bus
    input wire irtr_pkg::irtr_wb_req_type wb_req,
    input wire irtr_pkg::irtr_wb_rsp_type wb_rsp,
    // Address phases
    input wire irtr_pkg::irtr_req_type req,
    input wire logic req_ready,
    input wire logic reject,
    input wire irtr_pkg::irtr_fwd_type fwd,
    input wire logic fwd_ready
);
    import irtr_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_ack; wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack; endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    property p_rsv; wb_rsp.ack && wb_req.adr[9:2] inside {[8'h70:8'h73], [8'h77:8'h7A]}
        |-> wb_rsp.dat[0] == 1'b0 && wb_rsp.dat[31:8] == 24'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set");
    property p_ans; req.valid && req_ready |=> fwd.valid != reject; endproperty
    a_ans: assert property (p_ans) else $error("no single answer");
    property p_zero; req.valid && req_ready && req.addr == 7'h00 |=> reject; endproperty
    a_zero: assert property (p_zero) else $error("zero address matched");
    property p_rw; req.valid && req_ready |=> !fwd.valid || fwd.rw == $past(req.rw); endproperty
    a_rw: assert property (p_rw) else $error("direction changed");
    property p_hold; fwd.valid && !fwd_ready |=> fwd.valid && $stable(fwd); endproperty
    a_hold: assert property (p_hold) else $error("forward not held");
    property p_busy; fwd.valid |-> !req_ready; endproperty
    a_busy: assert property (p_busy) else $error("ready while pending");
    property p_tgt; fwd.valid |-> fwd.addr != 7'h00; endproperty
    a_tgt: assert property (p_tgt) else $error("zero target forwarded");
endmodule
bind irtr_remap irtr_remap_props u_props (.clk(clk), .reset_n(reset_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .req(req), .req_ready(req_ready), .reject(reject), .fwd(fwd), .fwd_ready(fwd_ready));
`default_nettype wire

// *** tb/irtr_host.sv ***
// Local controller model offering address phases
`timescale 1ns/10ps
`default_nettype none
module irtr_host
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Command from the bench
    input wire logic go,
    input wire logic [7:0] pa,
    // Address phase
    input wire logic req_ready,
    output irtr_pkg::irtr_req_type req
);
    import irtr_pkg::*;
    // Released phase shows inverted junk
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
            req <= '0;
        else if (req.valid && req_ready)
            req <= {1'b0, ~req.addr, ~req.rw};
        else if (go)
            req <= {1'b1, pa};
endmodule
`default_nettype wire

// *** tb/irtr_remap_bench.sv ***
// Self-checking bench for the remap block
`timescale 1ns/10ps
`default_nettype none
module irtr_remap_bench;
    import irtr_pkg::*;
    logic clk, reset_n, req_ready, reject, fwd_ready, go;
    logic [7:0] pa;
    logic [31:0] q;
    irtr_wb_req_type wreq;
    irtr_wb_rsp_type wrsp;
    irtr_req_type req;
    irtr_fwd_type fwd;
    int miscompares, samples_checked, lslot, tgt[4], als[4];
    irtr_remap dut (.clk(clk), .reset_n(reset_n), .wb_req(wreq), .wb_rsp(wrsp), .req(req),
        .req_ready(req_ready), .reject(reject), .fwd(fwd), .fwd_ready(fwd_ready));
    irtr_host host (.clk(clk), .reset_n(reset_n), .go(go), .pa(pa), .req_ready(req_ready), .req(req));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic wrap_up;
        if (miscompares == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (e !== g)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic guard(input int n);
        if (n >= 20)
        begin
            miscompares++;
            wrap_up;
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s);
        int n;
        @(posedge clk);
        wreq <= '{1'b1, 1'b1, we, {idx, 2'b00}, s, {24'h0, d}};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wrsp.ack !== 1'b1 && n < 20);
        q = wrsp.dat;
        wreq.cyc <= 1'b0;
        wreq.stb <= 1'b0;
        guard(n);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input int v);
        wb(1'b0, idx, 8'h00, 4'hF);
        check("register", {24'h0, v[6:0], 1'b0}, q);
    endtask
    task automatic offer(input logic [6:0] a, input logic rw);
        int n;
        int s;
        s = -1;
        for (int i = 3; i >= 0; i--)
            if (als[i] == a && a != 0 && tgt[i] != 0)
                s = i;
        @(posedge clk);
        go <= 1'b1;
        pa <= {a, rw};
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (fwd.valid !== 1'b1 && reject !== 1'b1 && n < 20);
        guard(n);
        if (s < 0)
            check("reject", 32'h1, {31'h0, reject});
        else
        begin
            check("forward", {21'h0, 1'b1, tgt[s][6:0], rw, s[1:0]}, {21'h0, fwd});
            lslot = s;
            repeat ($urandom % 3) @(posedge clk);
            @(posedge clk);
            fwd_ready <= 1'b1;
            @(posedge clk);
            fwd_ready <= 1'b0;
        end
        // Status: last hit flag and last matched slot
        wb(1'b0, 8'h7B, 8'h00, 4'hF);
        check("status", 32'(lslot + ((s >= 0) ? 4 : 0)), q);
    endtask
    initial
    begin
        reset_n = 1'b0;
        wreq = '0;
        go = 1'b0;
        pa = 8'h00;
        fwd_ready = 1'b0;
        miscompares = 0;
        samples_checked = 0;
        lslot = 0;
        void'($urandom(30760));
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            tgt[i] = (i == 2) ? 0 : $urandom_range(127, 1);
            als[i] = $urandom_range(127, 1);
            rd_chk(8'(8'h70 + i), 0);
            rd_chk(8'(8'h77 + i), 0);
            wb(1'b1, 8'(8'h70 + i), {tgt[i][6:0], 1'b1}, 4'hF);
            wb(1'b1, 8'(8'h77 + i), {als[i][6:0], 1'b1}, 4'hF);
        end
        wb(1'b1, 8'h70, 8'hFE, 4'h0);
        for (int i = 0; i < 4; i++)
        begin
            rd_chk(8'(8'h70 + i), tgt[i]);
            rd_chk(8'(8'h77 + i), als[i]);
        end
        rd_chk(8'h20, 0);
        for (int i = 0; i < 4; i++)
            offer(als[i][6:0], 1'(i));
        repeat (8)
            offer(7'($urandom), 1'($urandom));
        offer(7'h00, 1'b1);
        wb(1'b1, 8'h77, 8'h00, 4'hF);
        q = als[0];
        als[0] = 0;
        offer(q[6:0], 1'b0);
        // Reset in mid-run clears the filled table
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            rd_chk(8'(8'h70 + i), 0);
            rd_chk(8'(8'h77 + i), 0);
        end
        rd_chk(8'h7B, 0);
        wrap_up;
    end
endmodule
`default_nettype wire
